// ==== fpes_pkg.sv ====
// Package of constants and carrier types for the flash program/erase status block.
package fpes_pkg;

    // ****************************************
    // Widths and bit positions
    // ****************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int PRI_SEL_W = 8;
    localparam int SEC_SEL_W = 4;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int ERROR_BIT = 5;

    // ****************************************
    // Command sequence figures
    // ****************************************
    localparam logic [2:0] PROG_VALID_PULSE = 3'h4;
    localparam logic [2:0] ERASE_VALID_PULSE = 3'h6;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROT_ERASE_US = 100;
    localparam int PROT_ERASE_CYC = (PROT_ERASE_US * 1000) / CLK_PERIOD_NS;
    localparam logic [15:0] PROT_ERASE_CNT = 16'(PROT_ERASE_CYC);
    localparam logic [15:0] PROG_TIMEOUT_CNT = 16'h0200;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef enum logic [1:0] {
        FPES_OP_PROG,
        FPES_OP_SECT_ERASE,
        FPES_OP_BULK_ERASE
    } fpes_op_e;

    typedef struct packed {
        logic valid;
        fpes_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic all_protected;
    } fpes_cmd_s;

    typedef struct packed {
        logic done;
        logic fail;
    } fpes_core_s;

endpackage

// ==== fpes_status.sv ====
// Status reporting of the flash during embedded program and erase cycles.
// Contract
// RQ1 - Polling bit reads inverse written bit while programming
// RQ2 - Status valid after fourth/sixth write pulse
// RQ3 - Master polls programmed address or erased sector
// RQ4 - Polling bit zero during erase, stored after
// RQ5 - Program into protected sector is ignored
// RQ6 - All-protected erase: polling zero about 100us
// RQ7 - Toggle bit inverts on each selected read
// RQ8 - Cycle end: toggle stops, array data returns
// RQ9 - Master sees two equal reads as done
// RQ10 - All-protected erase: toggle zero about 100us
// RQ11 - Error bit zero normally, one on failure
// RQ12 - Error when programming zero back to one
// RQ13 - Error may flag program timeout
// RQ14 - Master abandons failed sector afterwards
// RQ15 - Error bit holds until reset-flash command
// RQ16 - Status on bits seven, six, five
module fpes_status (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sector selects and read strobe from the core
    input wire logic [fpes_pkg::PRI_SEL_W-1:0] primary_sector_selects,
    input wire logic [fpes_pkg::SEC_SEL_W-1:0] secondary_sector_selects,
    input wire logic rd_strobe,
    input wire logic [fpes_pkg::DATA_W-1:0] array_rd_data,
    // Command sequencer side
    input wire logic write_pulse,
    input wire fpes_pkg::fpes_cmd_s cmd,
    input wire logic protected_sel,
    input wire logic reset_flash_cmd,
    input wire fpes_pkg::fpes_core_s core,
    // Array program request
    output logic prog_en,
    // Read data and status
    output logic [fpes_pkg::DATA_W-1:0] rd_data,
    output logic busy,
    output logic error_status_bit
);

    // ****************************************
    // Cycle state
    // ****************************************
    typedef enum logic [1:0] {
        FPES_IDLE,
        FPES_PROG,
        FPES_ERASE,
        FPES_PROT_ERASE
    } fpes_state_e;

    fpes_state_e state_ff, nxt_state;
    logic [2:0] pulse_cnt_ff, nxt_pulse_cnt;
    logic [15:0] timer_ff, nxt_timer;
    logic [fpes_pkg::DATA_W-1:0] wr_data_ff, nxt_wr_data;
    logic [15:0] prot_cyc_ff, nxt_prot_cyc;
    logic toggle_ff, nxt_toggle;
    logic error_ff, nxt_error;
    logic [fpes_pkg::DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic selected;
    logic valid_now;
    logic [2:0] need_pulses;

    assign selected = (|primary_sector_selects) | (|secondary_sector_selects);
    assign need_pulses = (cmd.op == fpes_pkg::FPES_OP_PROG) ?
        fpes_pkg::PROG_VALID_PULSE : fpes_pkg::ERASE_VALID_PULSE;
    // Status only starts once the final write pulse of the sequence lands.
    assign valid_now = cmd.valid & write_pulse & (pulse_cnt_ff + 3'h1 >= need_pulses); // RQ2

    always_comb begin
        nxt_state = state_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_timer = timer_ff;
        nxt_wr_data = wr_data_ff;
        nxt_error = error_ff;
        prog_en = 1'b0;
        // The clear comes first so that any failure in the same cycle outranks it.
        if (reset_flash_cmd) begin
            nxt_error = 1'b0; // RQ15
        end
        if (write_pulse && state_ff == FPES_IDLE) begin
            nxt_pulse_cnt = valid_now ? 3'h0 : pulse_cnt_ff + 3'h1;
        end
        case (state_ff)
            FPES_IDLE: begin
                if (valid_now) begin
                    nxt_timer = 16'h0000;
                    if (cmd.op == fpes_pkg::FPES_OP_PROG) begin
                        // A protected target leaves the array untouched.
                        if (!protected_sel) begin // RQ5
                            nxt_state = FPES_PROG;
                            nxt_wr_data = cmd.data;
                            prog_en = 1'b1;
                            // Bits cannot go from zero back to one by programming.
                            if (|(cmd.data & ~array_rd_data)) begin // RQ12
                                nxt_error = 1'b1; // RQ11
                            end
                        end
                    end else if (cmd.all_protected) begin
                        nxt_state = FPES_PROT_ERASE; // RQ6 RQ10
                    end else begin
                        nxt_state = FPES_ERASE;
                    end
                end
            end
            FPES_PROG: begin
                nxt_timer = timer_ff + 16'h0001;
                if (core.done) begin
                    nxt_state = FPES_IDLE; // RQ8
                end else if (timer_ff == fpes_pkg::PROG_TIMEOUT_CNT) begin
                    nxt_state = FPES_IDLE;
                    nxt_error = 1'b1; // RQ13
                end
                if (core.fail) begin
                    nxt_error = 1'b1; // RQ11
                end
            end
            FPES_ERASE: begin
                if (core.done) begin
                    nxt_state = FPES_IDLE; // RQ8
                end
                if (core.fail) begin
                    nxt_error = 1'b1; // RQ11
                end
            end
            FPES_PROT_ERASE: begin
                nxt_timer = timer_ff + 16'h0001;
                if (timer_ff == fpes_pkg::PROT_ERASE_CNT - 16'h0001) begin
                    nxt_state = FPES_IDLE; // RQ6 RQ10
                end
            end
            default: nxt_state = FPES_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= FPES_IDLE;
            pulse_cnt_ff <= 3'h0;
            timer_ff <= 16'h0000;
            wr_data_ff <= fpes_pkg::DATA_RST;
            error_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pulse_cnt_ff <= nxt_pulse_cnt;
            timer_ff <= nxt_timer;
            wr_data_ff <= nxt_wr_data;
            error_ff <= nxt_error;
        end
    end

    // ****************************************
    // Read data path
    // ****************************************
    always_comb begin
        nxt_toggle = toggle_ff;
        nxt_rd_data = rd_data_ff;
        if (rd_strobe && selected) begin
            nxt_rd_data = array_rd_data; // RQ8
            case (state_ff)
                FPES_PROG: begin
                    nxt_toggle = ~toggle_ff; // RQ7
                    nxt_rd_data[fpes_pkg::POLL_BIT] = ~wr_data_ff[fpes_pkg::POLL_BIT]; // RQ1 RQ16
                    nxt_rd_data[fpes_pkg::TOGGLE_BIT] = toggle_ff; // RQ16
                    nxt_rd_data[fpes_pkg::ERROR_BIT] = error_ff; // RQ16
                end
                FPES_ERASE: begin
                    nxt_toggle = ~toggle_ff; // RQ7
                    nxt_rd_data[fpes_pkg::POLL_BIT] = 1'b0; // RQ4 RQ16
                    nxt_rd_data[fpes_pkg::TOGGLE_BIT] = toggle_ff;
                    nxt_rd_data[fpes_pkg::ERROR_BIT] = error_ff;
                end
                FPES_PROT_ERASE: begin
                    nxt_toggle = 1'b0;
                    nxt_rd_data[fpes_pkg::POLL_BIT] = 1'b0; // RQ6
                    nxt_rd_data[fpes_pkg::TOGGLE_BIT] = 1'b0; // RQ10
                    nxt_rd_data[fpes_pkg::ERROR_BIT] = error_ff;
                end
                default: begin
                    nxt_rd_data = array_rd_data;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            toggle_ff <= 1'b0;
            rd_data_ff <= fpes_pkg::DATA_RST;
        end else begin
            toggle_ff <= nxt_toggle;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
    assign busy = (state_ff != FPES_IDLE);
    assign error_status_bit = error_ff;

    // ****************************************
    // Check helpers
    // ****************************************
    // Counts cycles spent in the protected-erase window. A counter keeps the
    // length check cheap where a long delay chain would not.
    always_comb begin
        nxt_prot_cyc = 16'h0000;
        if (state_ff == FPES_PROT_ERASE) begin
            nxt_prot_cyc = prot_cyc_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prot_cyc_ff <= 16'h0000;
        end else begin
            prot_cyc_ff <= nxt_prot_cyc;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_prog_read;
        rd_strobe && selected && state_ff == FPES_PROG;
    endsequence

    sequence s_erase_read;
        rd_strobe && selected && state_ff == FPES_ERASE;
    endsequence

    a_poll_inverse: assert property (@(posedge clk) disable iff (rst) // RQ1
        s_prog_read |=> rd_data[7] == ~$past(wr_data_ff[7]))
        else $error("polling bit not inverted during program");

    a_erase_poll_zero: assert property (@(posedge clk) disable iff (rst) // RQ4
        rd_strobe && selected && state_ff == FPES_ERASE |=> rd_data[7] == 1'b0)
        else $error("polling bit not zero during erase");

    a_toggle_flips: assert property (@(posedge clk) disable iff (rst) // RQ7
        s_prog_read ##1 s_prog_read |=> rd_data[6] != $past(rd_data[6]))
        else $error("toggle bit did not change between reads");

    a_idle_array_data: assert property (@(posedge clk) disable iff (rst) // RQ8
        rd_strobe && selected && state_ff == FPES_IDLE |=> rd_data == $past(array_rd_data))
        else $error("array data not returned when idle");

    a_prot_erase_len: assert property (@(posedge clk) disable iff (rst) // RQ6
        state_ff == FPES_PROT_ERASE && prot_cyc_ff != fpes_pkg::PROT_ERASE_CNT - 16'h0001
        |=> state_ff == FPES_PROT_ERASE)
        else $error("protected erase window ended early");

    a_prot_erase_end: assert property (@(posedge clk) disable iff (rst) // RQ10
        state_ff == FPES_PROT_ERASE && prot_cyc_ff == fpes_pkg::PROT_ERASE_CNT - 16'h0001
        |=> state_ff == FPES_IDLE)
        else $error("protected erase window did not end");

    a_prog_timeout: assert property (@(posedge clk) disable iff (rst) // RQ13
        state_ff == FPES_PROG && !core.done && timer_ff == fpes_pkg::PROG_TIMEOUT_CNT
        |=> state_ff == FPES_IDLE && error_status_bit)
        else $error("program timeout not flagged");

    a_err_clear: assert property (@(posedge clk) disable iff (rst) // RQ15
        reset_flash_cmd && state_ff == FPES_IDLE && !valid_now |=> !error_status_bit)
        else $error("reset-flash did not clear error bit");

    a_status_err_bit: assert property (@(posedge clk) disable iff (rst) // RQ16
        rd_strobe && selected && state_ff != FPES_IDLE |=> rd_data[5] == $past(error_ff))
        else $error("error bit not on read data during cycle");

    a_erase_toggle: assert property (@(posedge clk) disable iff (rst) // RQ7
        s_erase_read ##1 s_erase_read |=> rd_data[6] != $past(rd_data[6]))
        else $error("toggle bit did not change during erase");

    a_read_hold: assert property (@(posedge clk) disable iff (rst) // RQ8
        !(rd_strobe && selected) |=> $stable(rd_data))
        else $error("read data changed without a selected read");

    a_prog_en_guard: assert property (@(posedge clk) disable iff (rst) // RQ5
        prog_en |-> state_ff == FPES_IDLE && cmd.op == fpes_pkg::FPES_OP_PROG
        && !protected_sel)
        else $error("program started on a protected sector");

    a_prot_toggle_zero: assert property (@(posedge clk) disable iff (rst) // RQ10
        rd_strobe && selected && state_ff == FPES_PROT_ERASE |=> rd_data[6] == 1'b0)
        else $error("toggle bit not zero in protected erase");

    a_protect_ignored: assert property (@(posedge clk) disable iff (rst) // RQ5
        valid_now && state_ff == FPES_IDLE && cmd.op == fpes_pkg::FPES_OP_PROG
        && protected_sel |-> !prog_en ##1 state_ff == FPES_IDLE)
        else $error("protected program not ignored");

    a_fail_sets_err: assert property (@(posedge clk) disable iff (rst) // RQ11
        core.fail && state_ff != FPES_IDLE |=> error_status_bit)
        else $error("error bit not set on failure");

    a_err_holds: assert property (@(posedge clk) disable iff (rst) // RQ15
        error_status_bit && !reset_flash_cmd |=> error_status_bit)
        else $error("error bit cleared without reset-flash");

    a_zero_to_one: assert property (@(posedge clk) disable iff (rst) // RQ12
        state_ff == FPES_IDLE && valid_now && cmd.op == fpes_pkg::FPES_OP_PROG
        && !protected_sel && |(cmd.data & ~array_rd_data) |=> error_status_bit)
        else $error("zero-to-one program not flagged");

    a_status_start: assert property (@(posedge clk) disable iff (rst) // RQ2
        state_ff == FPES_IDLE && !valid_now |=> state_ff == FPES_IDLE)
        else $error("cycle began before final write pulse");

endmodule // fpes_status

// ==== fpes_engine_model.sv ====
// Behavioural array engine that ends program and erase cycles.
module fpes_engine_model #(
    parameter int DELAY = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Cycle state and test controls
    input wire logic busy,
    input wire logic stall,
    input wire logic fail_req,
    // Engine result
    output fpes_pkg::fpes_core_s core
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // A stalled engine never finishes, so only the block's program timeout and protected-erase timer can end the cycle.
    always @(negedge clk) begin
        core <= '0;
        cnt <= (busy && !rst) ? cnt + 1 : 0;
        if (busy && !stall && cnt == DELAY) begin
            core <= '{done: 1'b1, fail: fail_req};
        end
    end
endmodule // fpes_engine_model

// ==== flash_program_erase_status_tb.sv ====
// Self-checking testbench of the flash program/erase status block.
module flash_program_erase_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] primary_sector_selects = 8'h00;
    logic [3:0] secondary_sector_selects = 4'h0;
    logic rd_strobe = 1'b0;
    logic [7:0] arr = 8'hFF;
    logic write_pulse = 1'b0;
    fpes_pkg::fpes_cmd_s cmd = '0;
    logic protected_sel = 1'b0;
    logic reset_flash_cmd = 1'b0;
    logic stall = 1'b0;
    logic fail_req = 1'b0;
    fpes_pkg::fpes_core_s core;
    logic prog_en;
    logic [7:0] rd_data;
    logic busy;
    logic error_status_bit;
    int error_cnt = 0;
    int check_count = 0;
    int seed = 32'hd54f;
    int tog = 0;
    int exp_err = 0;
    int bsy = 0;
    int poll = 0;
    int k;
    logic [7:0] d;
    logic [7:0] last;
    initial forever #50 clk = ~clk;
    fpes_status dut (.clk(clk), .rst(rst), .primary_sector_selects(primary_sector_selects),
        .secondary_sector_selects(secondary_sector_selects), .rd_strobe(rd_strobe),
        .array_rd_data(arr), .write_pulse(write_pulse), .cmd(cmd),
        .protected_sel(protected_sel), .reset_flash_cmd(reset_flash_cmd), .core(core),
        .prog_en(prog_en), .rd_data(rd_data), .busy(busy),
        .error_status_bit(error_status_bit));
    fpes_engine_model eng (.clk(clk), .rst(rst), .busy(busy), .stall(stall),
        .fail_req(fail_req), .core(core));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One command sequence; old is the stored byte seen at the final pulse.
    task automatic wr(input fpes_pkg::fpes_op_e op, input logic [7:0] dat, input int n,
                      input logic [7:0] old, input logic pe, input logic ap);
        rd_strobe = 1'b0;
        for (int i = 0; i < n; i++) begin
            write_pulse = 1'b1;
            arr = old;
            cmd = '{valid: 1'b1, op: op, addr: 16'($random(seed)), data: dat, all_protected: ap};
            #1;
            chk(8'(prog_en), 8'(pe && i == n - 1), "prog_en");
            @(negedge clk);
        end
        write_pulse = 1'b0;
        cmd.valid = 1'b0;
        @(negedge clk);
    endtask
    // A read at a random select; the master's model gives the expected byte.
    // The strobe stays up so reads run back to back; wr and wait_idle drop it.
    task automatic rd(input logic [7:0] m);
        logic [7:0] e;
        primary_sector_selects = 8'($random(seed));
        secondary_sector_selects = 4'($random(seed)) | 4'(primary_sector_selects == 8'h00);
        arr = 8'($random(seed));
        rd_strobe = 1'b1;
        e = bsy ? {1'(poll), 1'(tog), 1'(exp_err), 5'h00} : arr;
        @(negedge clk);
        chk(rd_data & (bsy ? m : 8'hFF), e & (bsy ? m : 8'hFF), "read");
        if (bsy) tog ^= 1;
    endtask
    task automatic wait_idle(input int lim);
        k = 0;
        rd_strobe = 1'b0;
        while (busy !== 1'b0 && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (busy !== 1'b0) begin
            error_cnt++;
            $display("mismatch at %0t: cycle never ended", $time);
            finish_test();
        end
        bsy = 0;
    endtask
    task automatic clr();
        reset_flash_cmd = 1'b1;
        @(negedge clk);
        reset_flash_cmd = 1'b0;
        exp_err = 0;
        chk(8'(error_status_bit), 8'h00, "error cleared");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        chk({busy, error_status_bit, rd_data[5:0]}, 8'h00, "reset values");
        rst = 1'b0;
        repeat (3) rd(8'hFF);
        arr = 8'($random(seed));
        last = rd_data;
        primary_sector_selects = 8'h00;
        secondary_sector_selects = 4'h0;
        rd_strobe = 1'b1;
        @(negedge clk);
        chk(rd_data, last, "unselected read");
        $display("test idle reads done");
        d = 8'($random(seed)) | 8'h01;
        wr(fpes_pkg::FPES_OP_PROG, d, 4, 8'hFF, 1'b1, 1'b0);
        chk(8'(busy), 8'h01, "busy after fourth pulse");
        bsy = 1;
        poll = int'(~d[7]);
        repeat (4) rd(8'hE0);
        wait_idle(100);
        arr = 8'($random(seed));
        repeat (2) rd(8'hFF);
        $display("test program done");
        wr(fpes_pkg::FPES_OP_PROG, 8'h80, 4, 8'h00, 1'b1, 1'b0);
        bsy = 1;
        exp_err = 1;
        poll = 0;
        rd(8'hA0);
        wait_idle(100);
        chk(8'(error_status_bit), 8'h01, "error holds");
        clr();
        $display("test zero to one done");
        protected_sel = 1'b1;
        wr(fpes_pkg::FPES_OP_PROG, 8'h55, 4, 8'hFF, 1'b0, 1'b0);
        chk(8'(busy), 8'h00, "protected program idle");
        protected_sel = 1'b0;
        $display("test protected program done");
        for (int o = 1; o < 3; o++) begin
            fail_req = (o == 1);
            wr(fpes_pkg::fpes_op_e'(o), 8'h00, 6, 8'hFF, 1'b0, 1'b0);
            chk(8'(busy), 8'h01, "busy after sixth pulse");
            bsy = 1;
            poll = 0;
            repeat (3) rd(8'hC0);
            wait_idle(100);
            chk(8'(error_status_bit), 8'(o == 1), "erase error");
            if (o == 1) clr();
        end
        fail_req = 1'b0;
        $display("test erase done");
        stall = 1'b1;
        wr(fpes_pkg::FPES_OP_BULK_ERASE, 8'h00, 6, 8'hFF, 1'b0, 1'b1);
        bsy = 1;
        poll = 0;
        tog = 0;
        rd(8'hE0);
        tog = 0;
        wait_idle(1100);
        chk(8'(k > 990), 8'h01, "protected erase window");
        rd(8'hFF);
        $display("test protected erase done");
        wr(fpes_pkg::FPES_OP_PROG, 8'h3C, 4, 8'hFF, 1'b1, 1'b0);
        bsy = 1;
        wait_idle(600);
        chk(8'(k > 500), 8'h01, "program timeout length");
        chk(8'(error_status_bit), 8'h01, "timeout error");
        stall = 1'b0;
        clr();
        $display("test timeout done");
        finish_test();
    end
endmodule // flash_program_erase_status_tb
